// ==== hdl/qtp_quad_dec.sv ====
// Four-times quadrature decoder: one step pulse per phase edge
`timescale 1ns/1ps
`default_nettype none
module qtp_quad_dec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic en_i,
  output logic step_o,
  output logic up_o
);
  logic a_ff, b_ff, step_ff, up_ff;
  wire logic a_chg = a_i ^ a_ff;
  wire logic b_chg = b_i ^ b_ff;
  // Both phases moving together is a glitch, not a count
  wire logic nxt_step = en_i & (a_chg ^ b_chg);
  wire logic nxt_up = a_i ^ b_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      step_ff <= 1'b0;
      up_ff <= 1'b0;
    end else begin
      a_ff <= a_i;
      b_ff <= b_i;
      step_ff <= nxt_step;
      up_ff <= nxt_up;
    end
  end

  assign step_o = step_ff;
  assign up_o = up_ff;
endmodule
`default_nettype wire

// ==== hdl/qtp_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module qtp_sync #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  // Level moves only once the last two stages agree
  wire logic [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire logic [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q_ff);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule
`default_nettype wire

// ==== hdl/qtp_top.sv ====
// Quadrature counter channel and cycle timer channel with APB registers
`timescale 1ns/1ps
`default_nettype none
module qtp_top
  import qtp_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PHASE_A_INPUT_I,
  input wire logic PHASE_B_INPUT_I,
  input wire logic INDEX_INPUT_PIN_I,
  output logic IRQ_O,
  output logic ADC_TRIG_O
);
  import qtp_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic psc_tick(input logic [2:0] sel, input logic [5:0] cnt);
    case (sel)
      PSC_DIV1: return 1'b1;
      PSC_DIV4: return &cnt[1:0];
      PSC_DIV16: return &cnt[3:0];
      PSC_DIV64: return &cnt[5:0];
      // External clock sources are not wired to this pair
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic clr_hit(input logic [2:0] sel, input logic [3:0] ev);
    case (sel)
      CLR_A: return ev[0];
      CLR_B: return ev[1];
      CLR_C: return ev[2];
      CLR_D: return ev[3];
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rsel(input logic hit, input logic [15:0] val);
    return hit ? {16'h0000, val} : 32'h0000_0000;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] c_ctrl_ff, c_mode_ff, c_ioh_ff, c_iol_ff, c_ier_ff;
  logic [15:0] c_cnt_ff, c_gra_ff, c_grb_ff, c_grc_ff, c_grd_ff;
  logic [7:0] q_ctrl_ff, q_mode_ff, q_io_ff, q_ier_ff;
  logic [15:0] q_cnt_ff, q_gra_ff, q_grb_ff;
  logic [4:0] run_ff;
  logic [15:0] stat_ff, mask_ff;
  // One free prescaler shared by both channels keeps their ticks aligned
  logic [5:0] psc_ff;
  logic idx_prev_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, irq_ff, adc_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic setup = PSEL_I & ~PENABLE_I;
  wire logic acc = PSEL_I & PENABLE_I & pready_ff;
  wire logic wr = acc & PWRITE_I;
  wire logic rd = acc & ~PWRITE_I;

  wire logic h_c_ctrl = PADDR_I == byte_addr(IDX_C_CTRL);
  wire logic h_c_mode = PADDR_I == byte_addr(IDX_C_MODE);
  wire logic h_c_ioh = PADDR_I == byte_addr(IDX_C_IOH);
  wire logic h_c_iol = PADDR_I == byte_addr(IDX_C_IOL);
  wire logic h_c_ier = PADDR_I == byte_addr(IDX_C_IER);
  wire logic h_c_cnt = PADDR_I == byte_addr(IDX_C_CNT);
  wire logic h_c_gra = PADDR_I == byte_addr(IDX_C_GRA);
  wire logic h_c_grb = PADDR_I == byte_addr(IDX_C_GRB);
  wire logic h_c_grc = PADDR_I == byte_addr(IDX_C_GRC);
  wire logic h_c_grd = PADDR_I == byte_addr(IDX_C_GRD);
  wire logic h_q_ctrl = PADDR_I == byte_addr(IDX_Q_CTRL);
  wire logic h_q_mode = PADDR_I == byte_addr(IDX_Q_MODE);
  wire logic h_q_io = PADDR_I == byte_addr(IDX_Q_IO);
  wire logic h_q_ier = PADDR_I == byte_addr(IDX_Q_IER);
  wire logic h_q_cnt = PADDR_I == byte_addr(IDX_Q_CNT);
  wire logic h_q_gra = PADDR_I == byte_addr(IDX_Q_GRA);
  wire logic h_q_grb = PADDR_I == byte_addr(IDX_Q_GRB);
  wire logic h_run = PADDR_I == byte_addr(IDX_RUN);
  wire logic h_stat = PADDR_I == byte_addr(IDX_IRQ_STAT);
  wire logic h_mask = PADDR_I == byte_addr(IDX_IRQ_MASK);

  wire logic mapped = |{h_c_ctrl, h_c_mode, h_c_ioh, h_c_iol, h_c_ier,
                        h_c_cnt, h_c_gra, h_c_grb, h_c_grc, h_c_grd,
                        h_q_ctrl, h_q_mode, h_q_io, h_q_ier, h_q_cnt,
                        h_q_gra, h_q_grb, h_run, h_stat, h_mask};

  wire logic [7:0] wb = PWDATA_I[7:0];
  wire logic [15:0] ww = PWDATA_I[15:0];

  wire logic [31:0] rd_val =
    rsel(h_c_ctrl, {8'h00, c_ctrl_ff}) | rsel(h_c_mode, {8'h00, c_mode_ff}) |
    rsel(h_c_ioh, {8'h00, c_ioh_ff}) | rsel(h_c_iol, {8'h00, c_iol_ff}) |
    rsel(h_c_ier, {8'h00, c_ier_ff}) | rsel(h_c_cnt, c_cnt_ff) |
    rsel(h_c_gra, c_gra_ff) | rsel(h_c_grb, c_grb_ff) |
    rsel(h_c_grc, c_grc_ff) | rsel(h_c_grd, c_grd_ff) |
    rsel(h_q_ctrl, {8'h00, q_ctrl_ff}) | rsel(h_q_mode, {8'h00, q_mode_ff}) |
    rsel(h_q_io, {8'h00, q_io_ff}) | rsel(h_q_ier, {8'h00, q_ier_ff}) |
    rsel(h_q_cnt, q_cnt_ff) | rsel(h_q_gra, q_gra_ff) |
    rsel(h_q_grb, q_grb_ff) | rsel(h_run, {11'h000, run_ff}) |
    rsel(h_stat, stat_ff) | rsel(h_mask, mask_ff);

  // ----------------------------------------
  // Pins and quadrature decode
  // ----------------------------------------
  logic [2:0] pins;
  logic dec_step, dec_up;

  qtp_sync #(
    .W(3)
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({INDEX_INPUT_PIN_I, PHASE_B_INPUT_I, PHASE_A_INPUT_I}),
    .q_o(pins)
  );

  qtp_quad_dec u_dec (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .a_i(pins[0]),
    .b_i(pins[1]),
    .en_i(run_ff[1]),
    .step_o(dec_step),
    .up_o(dec_up)
  );

  wire logic index_rise = pins[2] & ~idx_prev_ff;

  // ----------------------------------------
  // Cycle timer channel
  // ----------------------------------------
  wire logic [2:0] c_clear_source_sel = c_ctrl_ff[CLEAR_SOURCE_SEL_LSB+:3];
  wire logic [3:0] c_ioa = c_ioh_ff[IOA_LSB+:4];
  wire logic [3:0] c_iob = c_ioh_ff[IOB_LSB+:4];
  wire logic [3:0] c_ioc = c_iol_ff[IOA_LSB+:4];
  wire logic [3:0] c_iod = c_iol_ff[IOB_LSB+:4];
  wire logic c_bfa = c_mode_ff[BFA_BIT];
  wire logic c_bfb = c_mode_ff[BFB_BIT];
  wire logic c_edge_ok = c_ctrl_ff[EDGE_LSB+:2] == EDGE_RISE;
  wire logic c_tick = run_ff[0] & c_edge_ok & psc_tick(c_ctrl_ff[PSC_LSB+:3], psc_ff);

  // A compare with a buffer partner lets C feed A, so C itself does not match
  wire logic c_cmp_a = c_tick & (c_ioa == IO_COMPARE) & (c_cnt_ff == c_gra_ff);
  wire logic c_cmp_b = c_tick & (c_iob == IO_COMPARE) & (c_cnt_ff == c_grb_ff);
  wire logic c_cmp_c = c_tick & ~c_bfa & (c_ioc == IO_COMPARE) & (c_cnt_ff == c_grc_ff);
  wire logic c_cmp_d = c_tick & ~c_bfb & (c_iod == IO_COMPARE) & (c_cnt_ff == c_grd_ff);

  // Forward declared quadrature step used by the B capture
  logic q_step;
  wire logic c_cap_b = (c_iob == IO_CAP_XCH) & q_step;
  wire logic c_ev_b = c_cmp_b | c_cap_b;
  wire logic c_clr = clr_hit(c_clear_source_sel, {c_cmp_d, c_cmp_c, c_ev_b, c_cmp_a});
  wire logic c_ovf = c_tick & ~c_clr & (c_cnt_ff == 16'hffff);

  wire logic [15:0] nxt_c_cnt =
    (wr & h_c_cnt) ? ww :
    c_clr ? RST_WORD :
    c_tick ? 16'(c_cnt_ff + 16'h0001) : c_cnt_ff;
  wire logic [15:0] nxt_c_gra =
    (wr & h_c_gra) ? ww : (c_bfa & c_cmp_a) ? c_grc_ff : c_gra_ff;
  wire logic [15:0] nxt_c_grb =
    (wr & h_c_grb) ? ww : c_cap_b ? c_cnt_ff : c_grb_ff;
  wire logic [15:0] nxt_c_grd =
    (wr & h_c_grd) ? ww : (c_cap_b & c_bfb) ? c_grb_ff : c_grd_ff;

  // ----------------------------------------
  // Quadrature channel
  // ----------------------------------------
  wire logic q_phase = q_mode_ff[MD_LSB+:4] == MD_PHASE1;
  wire logic q_normal = q_mode_ff[MD_LSB+:4] == MD_NORMAL;
  wire logic q_edge_ok = q_ctrl_ff[EDGE_LSB+:2] == EDGE_RISE;
  wire logic q_int_tick = q_normal & q_edge_ok & psc_tick(q_ctrl_ff[PSC_LSB+:3], psc_ff);
  // Phase mode overrides prescaler and edge, and counts both ways
  assign q_step = run_ff[1] & (q_phase ? dec_step : q_int_tick);
  wire logic q_up = q_phase ? dec_up : 1'b1;

  wire logic [3:0] q_ioa = q_io_ff[IOA_LSB+:4];
  wire logic [3:0] q_iob = q_io_ff[IOB_LSB+:4];
  wire logic q_cap_a = (q_ioa == IO_CAP_RISE) & index_rise;
  wire logic q_cap_b = (q_iob == IO_CAP_XCH) & c_cmp_c;
  wire logic q_cmp_a = q_step & (q_ioa == IO_COMPARE) & (q_cnt_ff == q_gra_ff);
  wire logic q_cmp_b = q_step & (q_iob == IO_COMPARE) & (q_cnt_ff == q_grb_ff);
  wire logic q_ev_a = q_cap_a | q_cmp_a;
  wire logic q_ev_b = q_cap_b | q_cmp_b;
  wire logic q_clr = clr_hit(q_ctrl_ff[CLEAR_SOURCE_SEL_LSB+:3], {2'b00, q_ev_b, q_ev_a});

  wire logic q_ovf = q_step & q_up & ~q_clr & (q_cnt_ff == 16'hffff);
  wire logic q_unf = q_step & ~q_up & ~q_clr & (q_cnt_ff == 16'h0000);

  wire logic [15:0] q_inc = 16'(q_cnt_ff + 16'h0001);
  wire logic [15:0] q_dec = 16'(q_cnt_ff - 16'h0001);
  wire logic [15:0] nxt_q_cnt =
    (wr & h_q_cnt) ? ww :
    q_clr ? RST_WORD :
    q_step ? (q_up ? q_inc : q_dec) : q_cnt_ff;
  // Capture takes the count before any clear of the same cycle
  wire logic [15:0] nxt_q_gra =
    (wr & h_q_gra) ? ww : q_cap_a ? q_cnt_ff : q_gra_ff;
  wire logic [15:0] nxt_q_grb =
    (wr & h_q_grb) ? ww : q_cap_b ? q_cnt_ff : q_grb_ff;

  // ----------------------------------------
  // Interrupt status and converter trigger
  // ----------------------------------------
  // Bit positions match the enable registers so one mask word covers both
  wire logic [15:0] ev_vec = {2'b00, q_unf, q_ovf, 2'b00, q_ev_b, q_ev_a,
                              3'b000, c_ovf, c_cmp_d, c_cmp_c, c_ev_b, c_cmp_a};
  wire logic [15:0] en_vec = {2'b00, q_ier_ff[5:0], 2'b00, c_ier_ff[5:0]};
  // Only bits that the read returned are cleared; a new event still wins
  wire logic [15:0] rd_clr = (rd & h_stat) ? prdata_ff[15:0] : 16'h0000;
  wire logic [15:0] nxt_stat = (stat_ff & ~rd_clr) | ev_vec;
  wire logic nxt_irq = |(stat_ff & mask_ff & en_vec);
  wire logic nxt_adc = (c_ier_ff[ADC_TRIGGER_ENABLE_BIT] & c_cmp_a) |
                       (q_ier_ff[ADC_TRIGGER_ENABLE_BIT] & q_ev_a);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      c_ctrl_ff <= RST_BYTE;
      c_mode_ff <= RST_BYTE;
      c_ioh_ff <= RST_BYTE;
      c_iol_ff <= RST_BYTE;
      c_ier_ff <= RST_BYTE;
      q_ctrl_ff <= RST_BYTE;
      q_mode_ff <= RST_BYTE;
      q_io_ff <= RST_BYTE;
      q_ier_ff <= RST_BYTE;
      run_ff <= RST_BYTE[4:0];
      mask_ff <= RST_WORD;
    end else begin
      if (wr & h_c_ctrl) c_ctrl_ff <= wb;
      if (wr & h_c_mode) c_mode_ff <= wb;
      if (wr & h_c_ioh) c_ioh_ff <= wb;
      if (wr & h_c_iol) c_iol_ff <= wb;
      if (wr & h_c_ier) c_ier_ff <= wb;
      if (wr & h_q_ctrl) q_ctrl_ff <= wb;
      if (wr & h_q_mode) q_mode_ff <= wb;
      if (wr & h_q_io) q_io_ff <= wb;
      if (wr & h_q_ier) q_ier_ff <= wb;
      if (wr & h_run) run_ff <= wb[4:0];
      if (wr & h_mask) mask_ff <= ww;
    end
  end

  // ----------------------------------------
  // Counters and general registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      c_cnt_ff <= RST_WORD;
      c_gra_ff <= RST_WORD;
      c_grb_ff <= RST_WORD;
      c_grc_ff <= RST_WORD;
      c_grd_ff <= RST_WORD;
      q_cnt_ff <= RST_WORD;
      q_gra_ff <= RST_WORD;
      q_grb_ff <= RST_WORD;
      psc_ff <= 6'h00;
      idx_prev_ff <= 1'b0;
    end else begin
      c_cnt_ff <= nxt_c_cnt;
      c_gra_ff <= nxt_c_gra;
      c_grb_ff <= nxt_c_grb;
      c_grc_ff <= (wr & h_c_grc) ? ww : c_grc_ff;
      c_grd_ff <= nxt_c_grd;
      q_cnt_ff <= nxt_q_cnt;
      q_gra_ff <= nxt_q_gra;
      q_grb_ff <= nxt_q_grb;
      psc_ff <= 6'(psc_ff + 6'h01);
      idx_prev_ff <= pins[2];
    end
  end

  // ----------------------------------------
  // Bus answer, status and outputs
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      stat_ff <= RST_WORD;
      irq_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else begin
      // No wait states: ready always follows setup by exactly one cycle
      if (setup) prdata_ff <= PWRITE_I ? 32'h0000_0000 : rd_val;
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      stat_ff <= nxt_stat;
      irq_ff <= nxt_irq;
      adc_ff <= nxt_adc;
    end
  end

  assign PRDATA_O = prdata_ff;
  assign PREADY_O = pready_ff;
  assign PSLVERR_O = pslverr_ff;
  assign IRQ_O = irq_ff;
  assign ADC_TRIG_O = adc_ff;

endmodule
`default_nettype wire

// ==== shared/qtp_pkg.sv ====
// Package: register map, field layout and codes of the quadrature timer pair
package qtp_pkg;

  // ----------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [31:0] IDX_C_CTRL = 32'hfffe4300;
  localparam logic [31:0] IDX_C_MODE = 32'hfffe4301;
  localparam logic [31:0] IDX_C_IOH = 32'hfffe4302;
  localparam logic [31:0] IDX_C_IOL = 32'hfffe4303;
  localparam logic [31:0] IDX_C_IER = 32'hfffe4304;
  localparam logic [31:0] IDX_C_CNT = 32'hfffe4306;
  localparam logic [31:0] IDX_C_GRA = 32'hfffe4308;
  localparam logic [31:0] IDX_C_GRB = 32'hfffe430a;
  localparam logic [31:0] IDX_C_GRC = 32'hfffe430c;
  localparam logic [31:0] IDX_C_GRD = 32'hfffe430e;
  localparam logic [31:0] IDX_Q_CTRL = 32'hfffe4380;
  localparam logic [31:0] IDX_Q_MODE = 32'hfffe4381;
  localparam logic [31:0] IDX_Q_IO = 32'hfffe4382;
  localparam logic [31:0] IDX_Q_IER = 32'hfffe4384;
  localparam logic [31:0] IDX_Q_CNT = 32'hfffe4386;
  localparam logic [31:0] IDX_Q_GRA = 32'hfffe4388;
  localparam logic [31:0] IDX_Q_GRB = 32'hfffe438a;
  localparam logic [31:0] IDX_RUN = 32'hffff4280;
  localparam logic [31:0] IDX_IRQ_STAT = 32'hfffe4390;
  localparam logic [31:0] IDX_IRQ_MASK = 32'hfffe4391;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CLEAR_SOURCE_SEL_LSB = 5;
  localparam int PSC_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int MD_LSB = 0;
  localparam int BFA_BIT = 4;
  localparam int BFB_BIT = 5;
  localparam int BFE_BIT = 6;
  localparam int IOA_LSB = 0;
  localparam int IOB_LSB = 4;
  localparam int ADC_TRIGGER_ENABLE_BIT = 7;
  localparam int Q_STAT_LSB = 8;

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [2:0] PSC_DIV1 = 3'h0;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [3:0] MD_NORMAL = 4'h0;
  localparam logic [3:0] MD_PHASE1 = 4'h4;
  localparam logic [3:0] IO_COMPARE = 4'h0;
  localparam logic [3:0] IO_CAP_RISE = 4'h8;
  localparam logic [3:0] IO_CAP_XCH = 4'hc;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int CYCLE_TIME_NS = 1000000;
  localparam int COUNT_CLK_NS = 20;
  // Value software loads for the 1 ms period at a 20 ns count clock
  localparam logic [15:0] CYCLE_LOAD = 16'(CYCLE_TIME_NS / COUNT_CLK_NS - 1);

endpackage

// ==== tb/qtp_enc_model.sv ====
// Two-phase rotary encoder with index output
`timescale 1ns/1ps
`default_nettype none
module qtp_enc_model (
  input wire logic clk_i,
  output logic a_o,
  output logic b_o,
  output logic z_o
);
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
    z_o = 1'b0;
  end
  // ----------------------------------------
  // Motion
  // ----------------------------------------
  // Eight cycles per level keeps each phase past the pin filter
  task automatic move(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_i);
      if (up) begin
        {a_o, b_o} <= {~b_o, a_o};
      end else begin
        {a_o, b_o} <= {b_o, ~a_o};
      end
    end
  endtask
  task automatic index_pulse();
    repeat (2) @(posedge clk_i);
    z_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    z_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/qtp_props.sv ====
// Checker: APB handshake and output timing properties of the timer pair
`timescale 1ns/1ps
`default_nettype none
module qtp_checker (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic PHASE_A_INPUT_I,
  input wire logic PHASE_B_INPUT_I,
  input wire logic INDEX_INPUT_PIN_I,
  input wire logic IRQ_O,
  input wire logic ADC_TRIG_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_cause; PREADY_O |-> $past(PSEL_I) && !$past(PENABLE_I); endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_once; PREADY_O |=> !PREADY_O; endproperty
  a_once: assert property (p_once) else $error("ready held too long");
  property p_err; PSLVERR_O |-> PREADY_O; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_wzero; PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0; endproperty
  a_wzero: assert property (p_wzero) else $error("read data on write");
  property p_upper; PREADY_O |-> PRDATA_O[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_trig; ADC_TRIG_O |=> !ADC_TRIG_O; endproperty
  a_trig: assert property (p_trig) else $error("trigger longer than a cycle");
  property p_rst; $rose(RST_N_I) |-> !IRQ_O && !PREADY_O && !ADC_TRIG_O; endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
endmodule
bind qtp_top qtp_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PHASE_A_INPUT_I(PHASE_A_INPUT_I), .PHASE_B_INPUT_I(PHASE_B_INPUT_I),
  .INDEX_INPUT_PIN_I(INDEX_INPUT_PIN_I), .IRQ_O(IRQ_O), .ADC_TRIG_O(ADC_TRIG_O));
`default_nettype wire

// ==== tb/quadrature_timer_pair_test.sv ====
// Testbench: registers, quadrature counting, captures and interrupt of the timer pair
`timescale 1ns/1ps
`default_nettype none
module quadrature_timer_pair_test;
  import qtp_pkg::*;
  typedef struct {logic [31:0] idx; logic [15:0] wd; logic err;} qtp_row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, trig, pa, pb, pz;
  logic [31:0] paddr, pwdata, prdata;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int trig_cnt = 0;
  qtp_row_s rows[5] = '{'{IDX_C_GRA, 16'h1234, 1'b0}, '{IDX_C_GRD, 16'ha5c3, 1'b0},
    '{IDX_Q_GRA, 16'h00ff, 1'b0}, '{IDX_C_IER, 16'h0002, 1'b0}, '{32'hfffe43f0, 16'h7777, 1'b1}};

  qtp_top DUT (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PHASE_A_INPUT_I(pa), .PHASE_B_INPUT_I(pb),
    .INDEX_INPUT_PIN_I(pz), .IRQ_O(irq), .ADC_TRIG_O(trig));
  qtp_enc_model enc (.clk_i(clk), .a_o(pa), .b_o(pb), .z_o(pz));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (trig === 1'b1) trig_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] idx, input logic [15:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, {16'h0, wd}, d, e);
  endtask
  task automatic rc(input logic [31:0] idx, input logic [15:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    chk(d, {16'h0, exp});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] x, y;
    logic e;
    int t0;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rc(rows[i].idx, 16'h0000);
      apb(1'b1, rows[i].idx, {16'h0, rows[i].wd}, x, e);
      chk({31'h0, e}, {31'h0, rows[i].err});
      rc(rows[i].idx, rows[i].err ? 16'h0000 : rows[i].wd);
    end
    $display("register table done");
    wr(IDX_Q_CNT, 16'h0000);
    wr(IDX_Q_CTRL, 16'h001b);
    wr(IDX_Q_MODE, 16'h0004);
    wr(IDX_Q_IER, 16'h0000);
    wr(IDX_IRQ_MASK, 16'h2000);
    wr(IDX_C_GRC, CYCLE_LOAD);
    rc(IDX_C_GRC, CYCLE_LOAD);
    // Short period keeps the run brief
    wr(IDX_C_GRC, 16'h0063);
    wr(IDX_C_CTRL, 16'h00a0);
    wr(IDX_C_MODE, 16'h0020);
    wr(IDX_C_IOH, 16'h00c0);
    wr(IDX_RUN, 16'h0003);
    enc.move(8, 1'b1);
    repeat (12) @(posedge clk);
    rc(IDX_Q_CNT, 16'h0008);
    enc.move(12, 1'b0);
    repeat (12) @(posedge clk);
    rc(IDX_Q_CNT, 16'hfffc);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_Q_IER, 16'h0020);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, IDX_IRQ_STAT, 32'h0, x, e);
    chk({30'h0, x[13:12]}, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("quadrature count done");
    apb(1'b0, IDX_C_GRB, 32'h0, x, e);
    enc.move(1, 1'b1);
    repeat (12) @(posedge clk);
    rc(IDX_C_GRD, x[15:0]);
    $display("buffered capture done");
    wr(IDX_Q_IO, 16'h0008);
    wr(IDX_Q_CTRL, 16'h0020);
    t0 = trig_cnt;
    enc.index_pulse();
    repeat (12) @(posedge clk);
    rc(IDX_Q_GRA, 16'hfffd);
    rc(IDX_Q_CNT, 16'h0000);
    chk(32'(trig_cnt - t0), 32'h0);
    wr(IDX_Q_IER, 16'h00a0);
    enc.index_pulse();
    repeat (12) @(posedge clk);
    chk(32'(trig_cnt - t0), 32'h1);
    $display("index capture done");
    wr(IDX_Q_IO, 16'h00c8);
    enc.move(4, 1'b1);
    repeat (120) @(posedge clk);
    rc(IDX_Q_GRB, 16'h0004);
    apb(1'b0, IDX_C_CNT, 32'h0, x, e);
    apb(1'b0, IDX_C_CNT, 32'h0, y, e);
    chk({31'h0, x > 32'd99}, 32'h0);
    chk(y, (x + 32'd3) % 32'd100);
    wr(IDX_RUN, 16'h0002);
    apb(1'b0, IDX_C_CNT, 32'h0, x, e);
    apb(1'b0, IDX_C_CNT, 32'h0, y, e);
    chk(y, x);
    $display("cycle timer done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rc(IDX_Q_GRB, 16'h0000);
    rc(IDX_Q_CNT, 16'h0000);
    rc(IDX_IRQ_STAT, 16'h0000);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_RUN, 16'h0002);
    apb(1'b0, IDX_Q_CNT, 32'h0, x, e);
    apb(1'b0, IDX_Q_CNT, 32'h0, y, e);
    chk(y, x + 32'd3);
    $display("reset and normal count done");
    finish_test();
  end
endmodule
`default_nettype wire
